// [fcl_fuse_model.sv]
module fcl_fuse_model (
    // clock
    input  wire logic       core_clk_i,
    // read request from the loader
    input  wire logic       fuse_rd_i,
    input  wire logic [3:0] fuse_addr_i,
    // answer to the loader
    output logic [7:0]      fuse_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16];        // fuse bytes, loaded by the bench
    logic [7:0] hold_reg;
    logic       vld_reg;

    // keep the byte for one cycle after the strobe, then let the line go
    always_ff @(posedge core_clk_i) begin
        hold_reg <= fuse_rd_i ? mem[fuse_addr_i] : hold_reg;
        vld_reg  <= fuse_rd_i;
    end
    // released line shows the inverse so a late capture cannot pass by luck
    assign fuse_data_o = fuse_rd_i ? mem[fuse_addr_i] : (vld_reg ? hold_reg : ~hold_reg);
endmodule // fcl_fuse_model

// [fcl_loader.sv]
module fcl_loader
    import fcl_pkg::*;
#(
    parameter int          MS_CYCLES    = MS_CYCLES_DEF,
    parameter int          TEMP_W       = 4,
    parameter logic [8:0]  FLASH_BLOCKS = 9'h020
) (
    // clock and resets
    input  wire logic              core_clk_i,
    input  wire logic              resetn_i,
    input  wire logic              por_resetn_i,
    // fuse storage, data in the same cycle as the read
    output logic                   fuse_rd_o,
    output logic [3:0]             fuse_addr_o,
    input  wire logic [7:0]        fuse_data_i,
    // factory calibration values
    input  wire logic [7:0]        cal16_freq_i,
    input  wire logic [TEMP_W-1:0] cal16_temp_i,
    input  wire logic [7:0]        cal20_freq_i,
    input  wire logic [TEMP_W-1:0] cal20_temp_i,
    // register port
    input  wire logic [3:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_we_i,
    input  wire logic              reg_re_i,
    output logic [7:0]             reg_rdata_o,
    // events from the system
    input  wire logic              chip_erase_i,
    input  wire logic              debug_enter_i,
    input  wire logic              fault_detect_setting_i,
    // oscillator
    output logic                   osc_run_20mhz_o,
    output logic [7:0]             osc_frequency_trim_o,
    output logic [TEMP_W-1:0]      osc_temperature_trim_o,
    // control timer
    output logic [7:0]             timer_fault_control_o,
    output logic [3:0]             compare_output_enable_o,
    output logic [3:0]             compare_default_level_o,
    // crc scan, reset pin, flash partition
    output logic                   crc_enable_o,
    output logic [1:0]             crc_scan_source_o,
    output logic                   pin_gpio_o,
    output logic                   pin_program_debug_o,
    output logic                   pin_ext_reset_o,
    output logic [8:0]             boot_end_blocks_o,
    output logic [8:0]             application_end_blocks_o,
    // lock, erase, cpu
    output logic                   device_locked_o,
    output logic                   debug_bus_allow_o,
    output logic                   eeprom_erase_o,
    output logic                   cpu_resetn_o
);

    // main state, cleared by general reset
    // one packed record so one comb block and one flop block carry it all
    typedef struct packed {
        fcl_state_t          st;
        logic [3:0]          addr;
        logic [7:0]          osc;
        logic [7:0]          sys0;
        logic [7:0]          sys1;
        logic [7:0]          app;
        logic [7:0]          boot;
        logic [7:0]          lock;
        logic [15:0]         tick;
        logic [6:0]          ms;
        logic [7:0]          rdata;
        logic                sel20;
        logic [7:0]          ftrim;
        logic [TEMP_W-1:0]   ttrim;
        logic                crc_en;
        logic [1:0]          crc_src;
        logic                p_gpio;
        logic                p_dbg;
        logic                p_rst;
        logic [8:0]          boot_end;
        logic [8:0]          app_end;
        logic                locked;
        logic                dbg_allow;
        logic                erase;
        logic                cpu_run;
    } fcl_main_t;

    // timer state, cleared only by power-on reset
    // kept apart from the main record since its reset is different
    typedef struct packed {
        logic       valid;
        logic [7:0] fault;
        logic [3:0] en;
        logic [3:0] lvl;
    } fcl_timer_t;

    // last tick of a millisecond; sixteen bits hold the default count,
    // a faster clock would need a wider counter
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    fcl_main_t  m_reg;
    fcl_main_t  m_next;
    fcl_timer_t t_reg;
    fcl_timer_t t_next;
    logic       rst_meta;
    logic       rst_sync_n;
    logic       por_meta;
    logic       por_sync_n;
    logic       fuse_rd_reg;
    logic       capt_timer;

    // reset release through two flops each
    // both resets assert at once but release only after two clean edges,
    // so no flop leaves reset on a runt edge; power-on reset has its own
    // pair because the timer group must tell it apart from the rest
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    always_ff @(posedge core_clk_i or negedge por_resetn_i) begin
        if (!por_resetn_i) begin
            por_meta   <= 1'b0;
            por_sync_n <= 1'b0;
        end else begin
            por_meta   <= 1'b1;
            por_sync_n <= por_meta;
        end
    end

    // timer byte captured only while its copy is stale since power-on
    // the valid flag tells a power-on load from a warm one; it is cleared
    // only with the group, so a warm reset skips the capture
    assign capt_timer = (m_reg.st == ST_CAPT) && (m_reg.addr == OFS_TIMER) && !t_reg.valid;

    always_comb begin
        t_next = t_reg;
        if (capt_timer) begin
            t_next.valid = 1'b1;                                          // [RULE_04]
            t_next.fault = fuse_data_i;                                   // [RULE_03]
            t_next.en    = fuse_data_i[TMR_EN_LO +: 4];                   // [RULE_05]
            t_next.lvl   = fuse_data_i[3:0];                              // [RULE_06]
        end else if (debug_enter_i && fault_detect_setting_i && t_reg.valid) begin
            t_next.lvl = t_reg.fault[3:0];                                // [RULE_06]
        end
    end

    // other resets leave this group alone, so settings survive them
    always_ff @(posedge core_clk_i or negedge por_sync_n) begin
        if (!por_sync_n) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    // load sequence, decode and register port
    // one fuse byte every two cycles: strobe, then capture while the strobe
    // still stands, since the fuse store answers in the strobe cycle;
    // reserved offsets are walked too, which keeps the address a plain counter
    always_comb begin
        m_next          = m_reg;
        m_next.rdata    = 8'h00;
        m_next.erase    = 1'b0;
        fuse_rd_reg     = 1'b0;
        unique case (m_reg.st)
            ST_READ: begin
                // the strobe is registered and leaves after one cycle
                fuse_rd_reg = 1'b1;                                       // [RULE_15]
                m_next.st   = ST_CAPT;
            end
            ST_CAPT: begin
                // reserved offsets are read too and dropped
                unique case (m_reg.addr)
                    OFS_OSC:     m_next.osc  = fuse_data_i;
                    OFS_SYS0:    m_next.sys0 = fuse_data_i & SYS0_MASK;
                    OFS_SYS1:    m_next.sys1 = fuse_data_i & SYS1_MASK;
                    OFS_APPLICATION_END_BLOCKS:  m_next.app  = fuse_data_i;
                    OFS_BOOT_END_BLOCKS: m_next.boot = fuse_data_i;
                    OFS_LOCK:    m_next.lock = fuse_data_i;
                    default:     m_next.addr = m_reg.addr;
                endcase
                if (m_reg.addr == OFS_LOCK) begin
                    m_next.st = ST_DELAY;
                    m_next.ms = 7'h00;
                end else begin
                    m_next.addr = m_reg.addr + 4'h1;
                    m_next.st   = ST_READ;
                end
            end
            ST_DELAY: begin
                // one tick per millisecond, cpu released when the count is met
                // the tick counter moves only here and reset clears it,
                // so every delay starts from zero
                if (m_reg.ms >= fcl_sut_ms(m_reg.sys1[2:0])) begin      // [RULE_10]
                    m_next.st      = ST_RUN;
                    m_next.cpu_run = 1'b1;                                // [RULE_15]
                end else if (m_reg.tick == MS_LAST) begin
                    m_next.tick = 16'h0000;
                    m_next.ms   = m_reg.ms + 7'h01;
                end else begin
                    m_next.tick = m_reg.tick + 16'h0001;
                end
            end
            ST_RUN: begin
                // stay here until the next reset
                m_next.cpu_run = 1'b1;
            end
        endcase

        // decoded outputs follow the shadows one cycle later
        // they are recomputed every cycle, so a lock write reaches the
        // lock and debug outputs one cycle after the shadow changes
        m_next.sel20 = (m_reg.osc[1:0] != FREQ_16);                      // [RULE_01]
        m_next.ftrim = m_next.sel20 ? cal20_freq_i : cal16_freq_i;        // [RULE_02]
        m_next.ttrim = m_next.sel20 ? cal20_temp_i : cal16_temp_i;        // [RULE_02]
        m_next.crc_src = m_reg.sys0[SYS0_CRC_LO +: 2];                    // [RULE_07]
        m_next.crc_en  = (m_next.crc_src != CRC_NONE);                    // [RULE_07]
        m_next.p_gpio  = (m_reg.sys0[SYS0_PIN_LO +: 2] == PIN_GPIO);      // [RULE_08]
        m_next.p_dbg   = (m_reg.sys0[SYS0_PIN_LO +: 2] == PIN_DEBUG);     // [RULE_08]
        m_next.p_rst   = (m_reg.sys0[SYS0_PIN_LO +: 2] == PIN_RESET);     // [RULE_08]
        // zero boot end means all boot, zero app end means code to the top
        m_next.boot_end = (m_reg.boot == 8'h00) ? FLASH_BLOCKS : {1'b0, m_reg.boot}; // [RULE_12]
        m_next.app_end  = (m_reg.app == 8'h00 || m_reg.boot == 8'h00) ?
                          FLASH_BLOCKS : {1'b0, m_reg.app};               // [RULE_11]
        m_next.locked    = (m_reg.lock != LOCK_OPEN);                     // [RULE_13]
        m_next.dbg_allow = !m_next.locked && (m_reg.st == ST_RUN);        // [RULE_13]

        // locked parts never keep eeprom contents
        // the decision uses the registered lock state, so an erase right
        // after a lock write still sees the old state
        if (chip_erase_i) begin
            m_next.erase = m_reg.locked || !m_reg.sys0[SYS0_EEPROM_PRESERVE];      // [RULE_09]
        end

        // only the lock byte is writable; bus writes wait for the load
        // a written value lasts until the next reset reloads the fuse byte
        if (reg_we_i && reg_addr_i == OFS_LOCK && m_reg.st == ST_RUN) begin
            m_next.lock = reg_wdata_i;
        end

        // read data lives one cycle and is zero otherwise, so a shared
        // read bus can simply or the slaves together
        if (reg_re_i) begin
            unique case (reg_addr_i)
                OFS_TIMER:   m_next.rdata = t_reg.fault;
                OFS_SYS0:    m_next.rdata = m_reg.sys0;
                OFS_SYS1:    m_next.rdata = m_reg.sys1;
                OFS_APPLICATION_END_BLOCKS:  m_next.rdata = m_reg.app;
                OFS_BOOT_END_BLOCKS: m_next.rdata = m_reg.boot;
                OFS_LOCK:    m_next.rdata = m_reg.lock;
                OFS_STATUS:  m_next.rdata = {5'h00, t_reg.valid, m_reg.locked, m_reg.cpu_run};
                default:     m_next.rdata = 8'h00;
            endcase
        end
    end

    // main register set
    // shadows start at their unprogrammed defaults so the decode is sane
    // before the first fuse byte arrives
    always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            m_reg         <= '0;
            m_reg.st      <= ST_READ;
            m_reg.addr    <= OFS_OSC;
            m_reg.osc     <= OSC_RST;
            m_reg.sys0    <= SYS0_RST;
            m_reg.sys1    <= SYS1_RST;
            m_reg.lock    <= LOCK_RST;
            m_reg.sel20   <= 1'b1;
            m_reg.crc_src <= CRC_NONE;
            m_reg.locked  <= 1'b1;
            fuse_rd_o     <= 1'b0;
            fuse_addr_o   <= OFS_OSC;
        end else begin
            m_reg         <= m_next;
            fuse_rd_o     <= fuse_rd_reg;
            fuse_addr_o   <= m_reg.addr;
        end
    end

    // every output straight from a flop
    // no logic after the flops keeps every output free of glitches
    assign reg_rdata_o              = m_reg.rdata;
    assign osc_run_20mhz_o          = m_reg.sel20;
    assign osc_frequency_trim_o     = m_reg.ftrim;
    assign osc_temperature_trim_o   = m_reg.ttrim;
    assign timer_fault_control_o    = t_reg.fault;
    assign compare_output_enable_o  = t_reg.en;
    assign compare_default_level_o  = t_reg.lvl;
    assign crc_enable_o             = m_reg.crc_en;
    assign crc_scan_source_o        = m_reg.crc_src;
    assign pin_gpio_o               = m_reg.p_gpio;
    assign pin_program_debug_o      = m_reg.p_dbg;
    assign pin_ext_reset_o          = m_reg.p_rst;
    assign boot_end_blocks_o        = m_reg.boot_end;
    assign application_end_blocks_o = m_reg.app_end;
    assign device_locked_o          = m_reg.locked;
    assign debug_bus_allow_o        = m_reg.dbg_allow;
    assign eeprom_erase_o           = m_reg.erase;
    assign cpu_resetn_o             = m_reg.cpu_run;

endmodule // fcl_loader

// [fcl_loader_monitor.sv]
module fcl_loader_mon
    import fcl_pkg::*;
(
    // clock and resets
    input wire logic       core_clk_i,
    input wire logic       resetn_i,
    input wire logic       por_resetn_i,
    // fuse strobe and inputs seen by the loader
    input wire logic       fuse_rd_o,
    input wire logic [7:0] cal16_freq_i,
    input wire logic [7:0] cal20_freq_i,
    input wire logic       chip_erase_i,
    input wire logic       debug_enter_i,
    input wire logic       fault_detect_setting_i,
    // decoded outputs
    input wire logic       osc_run_20mhz_o,
    input wire logic [7:0] osc_frequency_trim_o,
    input wire logic [7:0] timer_fault_control_o,
    input wire logic [3:0] compare_output_enable_o,
    input wire logic [3:0] compare_default_level_o,
    input wire logic       crc_enable_o,
    input wire logic [1:0] crc_scan_source_o,
    input wire logic       pin_gpio_o,
    input wire logic       pin_program_debug_o,
    input wire logic       pin_ext_reset_o,
    input wire logic       device_locked_o,
    input wire logic       debug_bus_allow_o,
    input wire logic       eeprom_erase_o,
    input wire logic       cpu_resetn_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // one clock domain; checks sleep during general reset, except a_timer_keep, which sleeps only during power-on reset
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // lock output lags its register, so never erase right after a lock write
    a_erase_locked: assert property (chip_erase_i && device_locked_o |=> eeprom_erase_o)
        else $error("eeprom kept on a locked part");
    a_bus_open: assert property (debug_bus_allow_o |-> !device_locked_o)
        else $error("debug bus open while locked");
    a_pin_single: assert property ($onehot0({pin_gpio_o, pin_program_debug_o, pin_ext_reset_o}))
        else $error("reset pin function not exclusive");
    a_crc_gate: assert property (crc_enable_o == (crc_scan_source_o != CRC_NONE))
        else $error("crc enable disagrees with source");
    a_trim_pick: assert property (cpu_resetn_o |->
        osc_frequency_trim_o == (osc_run_20mhz_o ? cal20_freq_i : cal16_freq_i))
        else $error("wrong frequency trim");
    a_cpu_held: assert property (fuse_rd_o |-> !cpu_resetn_o ##1 !cpu_resetn_o)
        else $error("cpu released during fuse load");
    a_enable_copy: assert property (cpu_resetn_o |->
        compare_output_enable_o == timer_fault_control_o[7:4])
        else $error("compare enables differ from timer byte");
    a_debug_level: assert property (debug_enter_i && fault_detect_setting_i && cpu_resetn_o
        |=> compare_default_level_o == timer_fault_control_o[3:0])
        else $error("debug entry did not restore levels");
    a_timer_keep: assert property (disable iff (!por_resetn_i)
        !resetn_i |=> $stable(timer_fault_control_o))
        else $error("timer byte changed in a non power-on reset");
endmodule // fcl_loader_mon

bind fcl_loader fcl_loader_mon fcl_loader_mon_i (.core_clk_i, .resetn_i, .por_resetn_i,
    .fuse_rd_o, .cal16_freq_i, .cal20_freq_i, .chip_erase_i, .debug_enter_i,
    .fault_detect_setting_i, .osc_run_20mhz_o, .osc_frequency_trim_o, .timer_fault_control_o,
    .compare_output_enable_o, .compare_default_level_o, .crc_enable_o, .crc_scan_source_o,
    .pin_gpio_o, .pin_program_debug_o, .pin_ext_reset_o, .device_locked_o,
    .debug_bus_allow_o, .eeprom_erase_o, .cpu_resetn_o);

// [fcl_pkg.sv]
//Contract
//RULE_01: the fast oscillator runs at 16 MHz for select code 0x1 and at 20 MHz for 0x2; other codes are reserved.
//RULE_02: the select code picks which factory frequency and temperature trims go to the oscillator.
//RULE_03: every bit of the timer fuse byte is copied to the same bit of the timer fault control byte.
//RULE_04: the timer enables and default levels reload only after power-on reset, never after other resets.
//RULE_05: enable bits 7:4 put compare outputs A..D on their pins when 1 and keep them off when 0.
//RULE_06: level bits 3:0 give each compare output its level after reset and on debug entry with fault detect set.
//RULE_07: crc source 00 scans all flash, 01 boot only, 10 boot plus application code, 11 disables the scan.
//RULE_08: reset pin code 0x0 is general purpose, 0x1 the program/debug pin, 0x2 external reset, 0x3 reserved.
//RULE_09: chip erase clears the eeprom when the preserve bit is 0, keeps it when 1, and always clears it when locked.
//RULE_10: start-up codes 0x0 to 0x7 give 0, 1, 2, 4, 8, 16, 32 and 64 ms from power-on to code execution.
//RULE_11: application end counts 256-byte blocks, flash above it is data, and 0x00 makes all flash from boot end code.
//RULE_12: boot end counts 256-byte blocks and 0x00 makes the whole flash the boot section.
//RULE_13: the part is open only for lock byte 0xC5; locked, the debugger gets no system bus, only its own space.
//RULE_14: the programmer sets application end to boot size plus application code size in 256-byte blocks.
//RULE_15: all fuse bytes are read once per reset and the cpu stays in reset until the decoded values are applied.
package fcl_pkg;
    // clock and start-up unit
    localparam int CORE_CLK_HZ     = 50_000_000;
    localparam int STARTUP_UNIT_MS = 1;
    localparam int MS_CYCLES_DEF   = CORE_CLK_HZ / 1000 * STARTUP_UNIT_MS;
    // fuse and register offsets
    localparam logic [3:0] OFS_OSC     = 4'h2;
    localparam logic [3:0] OFS_TIMER   = 4'h4;
    localparam logic [3:0] OFS_SYS0    = 4'h5;
    localparam logic [3:0] OFS_SYS1    = 4'h6;
    localparam logic [3:0] OFS_APPLICATION_END_BLOCKS  = 4'h7;
    localparam logic [3:0] OFS_BOOT_END_BLOCKS = 4'h8;
    localparam logic [3:0] OFS_LOCK    = 4'hA;
    localparam logic [3:0] OFS_STATUS  = 4'hC;
    // values after reset and read masks
    localparam logic [7:0] OSC_RST   = 8'h02;
    localparam logic [7:0] SYS0_RST  = 8'hC4;
    localparam logic [7:0] SYS1_RST  = 8'h07;
    localparam logic [7:0] LOCK_RST  = 8'h00;
    localparam logic [7:0] SYS0_MASK = 8'hCD;
    localparam logic [7:0] SYS1_MASK = 8'h07;
    localparam logic [7:0] LOCK_OPEN = 8'hC5;
    // field codes and positions
    localparam logic [1:0] FREQ_16   = 2'h1;
    localparam logic [1:0] FREQ_20   = 2'h2;
    localparam logic [1:0] CRC_NONE  = 2'h3;
    localparam logic [1:0] PIN_GPIO  = 2'h0;
    localparam logic [1:0] PIN_DEBUG = 2'h1;
    localparam logic [1:0] PIN_RESET = 2'h2;
    localparam int SYS0_CRC_LO = 6;
    localparam int SYS0_PIN_LO = 2;
    localparam int SYS0_EEPROM_PRESERVE = 0;
    localparam int TMR_EN_LO   = 4;

    // load sequence states
    typedef enum logic [3:0] {
        ST_READ  = 4'b0001,
        ST_CAPT  = 4'b0010,
        ST_DELAY = 4'b0100,
        ST_RUN   = 4'b1000
    } fcl_state_t;

    // start-up code to milliseconds: 0, then doubling from 1
    function automatic logic [6:0] fcl_sut_ms(input logic [2:0] code);
        fcl_sut_ms = (code == 3'h0) ? 7'h00 : (7'h01 << (code - 3'h1));
    endfunction
endpackage

// [tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fcl_pkg::*;
    localparam int         MS    = 4;      // short millisecond for simulation
    localparam logic [8:0] FLASH = 9'h020;
    logic       core_clk_i, resetn_i, por_resetn_i, reg_we_i, reg_re_i, chip_erase_i;
    logic       debug_enter_i, fault_detect_setting_i, fuse_rd_o, osc_run_20mhz_o;
    logic       crc_enable_o, pin_gpio_o, pin_program_debug_o, pin_ext_reset_o;
    logic       device_locked_o, debug_bus_allow_o, eeprom_erase_o, cpu_resetn_o;
    logic [1:0] crc_scan_source_o;
    logic [3:0] reg_addr_i, cal16_temp_i, cal20_temp_i, fuse_addr_o, osc_temperature_trim_o;
    logic [3:0] compare_output_enable_o, compare_default_level_o;
    logic [7:0] fuse_data_i, cal16_freq_i, cal20_freq_i, reg_wdata_i, reg_rdata_o;
    logic [7:0] osc_frequency_trim_o, timer_fault_control_o;
    logic [8:0] boot_end_blocks_o, application_end_blocks_o;
    int         n_errors = 0, num_checks = 0, cycles = 0;

    fcl_loader #(.MS_CYCLES(MS)) fcl_loader_i (.*);
    fcl_fuse_model fcl_fuse_model_i (.core_clk_i, .fuse_rd_i(fuse_rd_o),
        .fuse_addr_i(fuse_addr_o), .fuse_data_o(fuse_data_i));

    // 50 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    // hang guard, far above eight loads with the longest delay
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_we_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_we_i <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_re_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_re_i <= 1'b0;
        @(negedge core_clk_i);
        chk(reg_rdata_o, exp);
    endtask
    task automatic erase(input logic exp);
        @(posedge core_clk_i);
        chip_erase_i <= 1'b1;
        @(posedge core_clk_i);
        chip_erase_i <= 1'b0;
        @(negedge core_clk_i);
        chk(eeprom_erase_o, exp);
    endtask
    // reset, then count cycles until the cpu is let go
    task automatic boot(input bit por, output int n);
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        if (por) por_resetn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        resetn_i     <= 1'b1;
        por_resetn_i <= 1'b1;
        n = 0;
        while (cpu_resetn_o !== 1'b1 && n < 2000) begin
            @(negedge core_clk_i);
            n++;
        end
        // debug access opens one cycle after the cpu is let go
        @(negedge core_clk_i);
    endtask

    // eight loads, one per start-up code; power-on only on the first and sixth
    initial begin
        logic [7:0] s0, s1, tm, ae, be, lk, tp;
        logic [1:0] fs;
        int         n, base;
        {resetn_i, por_resetn_i, reg_we_i, reg_re_i, chip_erase_i} = '0;
        {debug_enter_i, fault_detect_setting_i, reg_addr_i, reg_wdata_i} = '0;
        void'($urandom(74));
        {cal16_freq_i, cal20_freq_i, cal16_temp_i, cal20_temp_i} = 24'($urandom);
        for (int i = 0; i < 8; i++) begin
            fs = 2'($urandom);
            tm = 8'($urandom);
            s0 = 8'($urandom);
            s1 = {5'($urandom), 3'(i)};
            be = 8'($urandom % 8);
            ae = (i == 3) ? 8'h00 : be + 8'($urandom % 8);
            lk = ($urandom % 2) ? LOCK_OPEN : 8'($urandom);
            fcl_fuse_model_i.mem[2] = {6'h00, fs};
            fcl_fuse_model_i.mem[4] = tm;
            fcl_fuse_model_i.mem[5] = s0;
            fcl_fuse_model_i.mem[6] = s1;
            fcl_fuse_model_i.mem[7] = ae;
            fcl_fuse_model_i.mem[8] = be;
            fcl_fuse_model_i.mem[10] = lk;
            boot(i == 0 || i == 5, n);
            if (i == 0 || i == 5) tp = tm;
            if (i == 0) base = n;
            else chk(16'(n - base), 16'(MS << (i - 1)));
            chk(osc_run_20mhz_o, fs != FREQ_16);
            chk({osc_frequency_trim_o, osc_temperature_trim_o}, (fs == FREQ_16) ?
                {cal16_freq_i, cal16_temp_i} : {cal20_freq_i, cal20_temp_i});
            chk(timer_fault_control_o, tp);
            chk({compare_output_enable_o, compare_default_level_o}, tp);
            chk({crc_enable_o, crc_scan_source_o}, {s0[7:6] != CRC_NONE, s0[7:6]});
            chk({pin_gpio_o, pin_program_debug_o, pin_ext_reset_o}, {s0[3:2] == PIN_GPIO,
                s0[3:2] == PIN_DEBUG, s0[3:2] == PIN_RESET});
            chk(boot_end_blocks_o, (be == 0) ? FLASH : 9'(be));
            chk(application_end_blocks_o, (be == 0 || ae == 0) ? FLASH : 9'(ae));
            chk({device_locked_o, debug_bus_allow_o}, {lk != LOCK_OPEN, lk == LOCK_OPEN});
            wr(OFS_SYS0, ~s0);
            rd(OFS_SYS0, s0 & SYS0_MASK);
            rd(OFS_SYS1, s1 & SYS1_MASK);
            rd(OFS_TIMER, tp);
            rd(OFS_APPLICATION_END_BLOCKS, ae);
            rd(OFS_BOOT_END_BLOCKS, be);
            rd(OFS_LOCK, lk);
            rd(4'h3, 8'h00);
            erase(lk != LOCK_OPEN || !s0[0]);
            wr(OFS_LOCK, LOCK_OPEN);
            @(posedge core_clk_i);
            @(negedge core_clk_i);
            chk({device_locked_o, debug_bus_allow_o}, 2'b01);
            erase(!s0[0]);
            wr(OFS_LOCK, 8'h3C);
            rd(OFS_LOCK, 8'h3C);
            chk({device_locked_o, debug_bus_allow_o}, 2'b10);
            rd(OFS_STATUS, 8'h07);
            erase(1'b1);
            @(posedge core_clk_i);
            fault_detect_setting_i <= 1'b1;
            debug_enter_i          <= 1'b1;
            @(posedge core_clk_i);
            debug_enter_i <= 1'b0;
            @(negedge core_clk_i);
            chk(compare_default_level_o, tp[3:0]);
        end
        end_sim();
    end
endmodule // tb_top
